// *** design/suc_pkg.sv ***
// shared constants, state codes and word helpers for the serial channel
// assumes a 32-bit apb slave with byte addresses on an 8-bit port
package suc_pkg;
   // -----------------------------------------------------------------
   // widths
   // -----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int WORD_W = 9;
   localparam int DIV_W = 7;
   localparam int CNT_W = 4;
   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_MODE_RX = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_COMM_TX = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_COMM_RX = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_DIV_TX = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_DIV_RX = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_TXDATA = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_RXDATA = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;
   // -----------------------------------------------------------------
   // field positions, masks and reset values
   // -----------------------------------------------------------------
   localparam int B_OPCLK = 15;
   localparam int B_CCS = 14;
   localparam int B_STS = 8;
   localparam int B_SIS = 6;
   localparam int B_MD_HI = 2;
   localparam int B_MD_LO = 1;
   localparam int B_IRQSRC = 0;
   localparam int B_TXE = 15;
   localparam int B_RXE = 14;
   localparam int B_EOC = 10;
   localparam int B_PTC_HI = 9;
   localparam int B_PTC_LO = 8;
   localparam int B_DIR = 7;
   localparam int B_SLC_HI = 5;
   localparam int B_SLC_LO = 4;
   localparam int B_DLS_HI = 1;
   localparam int B_DLS_LO = 0;
   localparam int B_DIV_HI = 15;
   localparam int B_DIV_LO = 9;
   localparam int C_START = 0;
   localparam int C_STOP = 1;
   localparam int S_RX_BUSY = 0;
   localparam int S_TX_BUSY = 1;
   localparam int S_RX_RUN = 2;
   localparam int S_PERR = 3;
   localparam int S_RX_FULL = 4;
   localparam logic [15:0] MODE_RX_WMASK = 16'hC147;
   localparam logic [15:0] MODE_RX_FIXED = 16'h0020;
   localparam logic [15:0] COMM_WMASK = 16'hF7B3;
   localparam logic [15:0] COMM_FIXED = 16'h0004;
   localparam logic [15:0] DIV_WMASK = 16'hFE00;
   localparam logic [15:0] REG_RESET = 16'h0000;
   // -----------------------------------------------------------------
   // field encodings and counts
   // -----------------------------------------------------------------
   localparam logic [1:0] MODE_UART = 2'h1;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [1:0] PAR_ODD = 2'h3;
   localparam logic [1:0] STOP_NONE = 2'h0;
   localparam logic [1:0] STOP_TWO = 2'h2;
   localparam logic [1:0] LEN9 = 2'h1;
   localparam logic [1:0] LEN7 = 2'h2;
   localparam logic [CNT_W-1:0] BITS9 = 4'h9;
   localparam logic [CNT_W-1:0] BITS8 = 4'h8;
   localparam logic [CNT_W-1:0] BITS7 = 4'h7;
   localparam logic [1:0] STOPS_ONE = 2'h1;
   localparam logic [1:0] STOPS_TWO = 2'h2;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_START = 5'h02,
      ST_DATA = 5'h04,
      ST_PAR = 5'h08,
      ST_STOP = 5'h10
   } suc_state_t;

   function automatic logic [CNT_W-1:0] suc_word_bits(input logic [1:0] len);
      case (len)
         LEN9: return BITS9;
         LEN7: return BITS7;
         default: return BITS8;
      endcase
   endfunction

   function automatic logic [WORD_W-1:0] suc_reverse(
      input logic [WORD_W-1:0] w, input logic [CNT_W-1:0] n);
      logic [WORD_W-1:0] r;
      r = '0;
      for (int i = 0; i < WORD_W; i++) begin
         if (i < int'(n)) begin
            r[i] = w[int'(n) - 1 - i];
         end
      end
      return r;
   endfunction

   function automatic logic suc_parity(input logic [WORD_W-1:0] w,
      input logic [CNT_W-1:0] n, input logic [1:0] sel);
      logic p;
      p = 1'b0;
      for (int i = 0; i < WORD_W; i++) begin
         if (i < int'(n)) begin
            p = p ^ w[i];
         end
      end
      if (sel == PAR_ODD) begin
         return ~p;
      end
      if (sel == PAR_EVEN) begin
         return p;
      end
      return 1'b0;
   endfunction
endpackage

// *** design/suc_baud.sv ***
// half-bit tick generator for one serial channel
// assumes src_tick is a one-cycle enable on the same clock
`timescale 1ns/1ps
module suc_baud (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic restart,
   input wire logic src_tick,
   input wire logic [suc_pkg::DIV_W-1:0] div,
   output logic half_tick
);
   import suc_pkg::*;

   logic [DIV_W-1:0] cnt;

   // -----------------------------------------------------------------
   // divider: a bit lasts 2*(div+1) source ticks, so half is div+1
   // -----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= '0;
         half_tick <= 1'b0;
      end else if (ce) begin
         half_tick <= 1'b0;
         if (restart) begin
            cnt <= '0;
         end else if (src_tick) begin
            if (cnt == div) begin
               cnt <= '0;
               half_tick <= 1'b1;
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   end
endmodule

// *** design/suc_uart_setup.sv ***
// serial channel pair: channel a transmits, channel b receives
// assumes apb master on CLOCK and prescaler ticks from the same domain
//
// How it works
// - rx bit clock comes from operation clock, or from serial clock pin
// - start select 0: software starts a frame; 1: line edge starts it
// - start edge select 0 takes falling edge, 1 takes rising edge
// - mode field: 00 clocked, 01 async, 10 two-wire; 11 never written
// - irq cause select 0: frame end, 1: receive buffer emptied
// - per-channel transmit and receive enables choose the direction
// - error mask bit 1 lets reception error interrupt out
// - transmit parity: none, constant zero, even or odd
// - receive parity: none, taken unchecked, even or odd checked
// - bit order select 0 sends msb first, 1 lsb first
// - stop field: none, one or two stop bits; 11 never written
// - length field: 01 nine, 10 seven, 11 eight bits; 00 unused
// - operation clock select picks prescaler tick 0 or 1
// - bit time is bit clock source tick (operation clock, or serial clock pin for rx) times 2*(divider+1)
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module suc_uart_setup (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [suc_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic PRESC0_TICK,
   input wire logic PRESC1_TICK,
   input wire logic SCK_IN,
   input wire logic RXD,
   output logic TXD,
   output logic RX_ERROR_IRQ,
   output logic CHANNEL_IRQ,
   output logic TX_END_IRQ
);
   import suc_pkg::*;

   logic [15:0] mode_rx;
   logic [15:0] comm_tx;
   logic [15:0] comm_rx;
   logic [15:0] div_tx;
   logic [15:0] div_rx;
   logic [31:0] rd_val;
   logic hit;
   logic acc;
   logic wr_fire;
   logic rd_fire;
   logic sw_start;
   logic sw_stop;
   logic tx_load;
   logic rx_read;
   logic perr_clr;
   logic rxd_s1, rxd_s2, sck_s1, sck_s2, sck_q;
   logic rx_lvl, rx_lvl_q;
   logic sck_rise;
   logic opclk_tick;
   logic rx_src;
   logic rx_half_tick, tx_half_tick;
   logic rx_restart, tx_restart;
   suc_state_t rx_state, tx_state;
   logic rx_half, tx_half;
   logic [CNT_W-1:0] rx_cnt, tx_cnt;
   logic [WORD_W-1:0] rx_shift, rx_data, tx_word;
   logic [1:0] tx_stops;
   logic rx_run, rx_full, perr;
   logic rx_ok, start_edge;
   logic rx_sample, tx_adv;
   logic [CNT_W-1:0] rx_n, tx_n;

   function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [15:0] nw, input logic [15:0] msk);
      return (old & ~msk) | (nw & msk);
   endfunction

   // -----------------------------------------------------------------
   // apb slave, one wait state on every access
   // -----------------------------------------------------------------
   assign acc = PSEL & PENABLE;
   assign wr_fire = acc & PREADY & PWRITE;
   assign rd_fire = acc & PREADY & ~PWRITE;
   assign sw_start = wr_fire & (PADDR == OFF_CTRL) & PWDATA[C_START];
   assign sw_stop = wr_fire & (PADDR == OFF_CTRL) & PWDATA[C_STOP];
   assign tx_load = wr_fire & (PADDR == OFF_TXDATA);
   assign rx_read = rd_fire & (PADDR == OFF_RXDATA);
   assign perr_clr = wr_fire & (PADDR == OFF_STATUS) & PWDATA[S_PERR];

   always_comb begin
      hit = 1'b1;
      rd_val = '0;
      case (PADDR)
         OFF_MODE_RX: rd_val[15:0] = mode_rx | MODE_RX_FIXED;
         OFF_COMM_TX: rd_val[15:0] = comm_tx | COMM_FIXED;
         OFF_COMM_RX: rd_val[15:0] = comm_rx | COMM_FIXED;
         OFF_DIV_TX: rd_val[15:0] = div_tx;
         OFF_DIV_RX: rd_val[15:0] = div_rx;
         OFF_CTRL: rd_val = '0;
         OFF_TXDATA: rd_val[WORD_W-1:0] = tx_word;
         OFF_RXDATA: rd_val[WORD_W-1:0] = rx_data;
         OFF_STATUS: begin
            rd_val[S_RX_BUSY] = rx_state != ST_IDLE;
            rd_val[S_TX_BUSY] = tx_state != ST_IDLE;
            rd_val[S_RX_RUN] = rx_run;
            rd_val[S_PERR] = perr;
            rd_val[S_RX_FULL] = rx_full;
         end
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         PREADY <= 1'b0;
         PRDATA <= '0;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         if (acc & ~PREADY) begin
            PREADY <= 1'b1;
            PRDATA <= rd_val;
            PSLVERR <= ~hit;
         end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         mode_rx <= REG_RESET;
         comm_tx <= REG_RESET;
         comm_rx <= REG_RESET;
         div_tx <= REG_RESET;
         div_rx <= REG_RESET;
      end else if (CE && wr_fire) begin
         case (PADDR)
            OFF_MODE_RX: mode_rx <= merge(mode_rx, PWDATA[15:0],
               MODE_RX_WMASK);
            OFF_COMM_TX: comm_tx <= merge(comm_tx, PWDATA[15:0],
               COMM_WMASK);
            OFF_COMM_RX: comm_rx <= merge(comm_rx, PWDATA[15:0],
               COMM_WMASK);
            OFF_DIV_TX: div_tx <= merge(div_tx, PWDATA[15:0], DIV_WMASK);
            OFF_DIV_RX: div_rx <= merge(div_rx, PWDATA[15:0], DIV_WMASK);
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // pin synchronisers and clock source choice
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         rxd_s1 <= 1'b1;
         rxd_s2 <= 1'b1;
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_q <= 1'b0;
         rx_lvl_q <= 1'b1;
      end else if (CE) begin
         rxd_s1 <= RXD;
         rxd_s2 <= rxd_s1;
         sck_s1 <= SCK_IN;
         sck_s2 <= sck_s1;
         sck_q <= sck_s2;
         rx_lvl_q <= rx_lvl;
      end
   end

   // inverting the line makes a rising edge look like a start bit
   assign rx_lvl = rxd_s2 ^ mode_rx[B_SIS];
   assign start_edge = rx_lvl_q & ~rx_lvl;
   assign sck_rise = sck_s2 & ~sck_q;
   assign opclk_tick = mode_rx[B_OPCLK] ? PRESC1_TICK : PRESC0_TICK;
   assign rx_src = mode_rx[B_CCS] ? sck_rise : opclk_tick;

   // only the async mode moves receive frames; the other modes hold the receiver idle
   assign rx_ok = comm_rx[B_RXE]
      & (mode_rx[B_MD_HI:B_MD_LO] == MODE_UART);
   assign rx_n = suc_word_bits(comm_rx[B_DLS_HI:B_DLS_LO]);
   assign tx_n = suc_word_bits(comm_tx[B_DLS_HI:B_DLS_LO]);
   assign rx_sample = rx_half_tick & rx_half;
   assign tx_adv = tx_half_tick & tx_half;
   assign rx_restart = (rx_state == ST_IDLE);
   assign tx_restart = (tx_state == ST_IDLE);

   suc_baud u_rx_baud (
      .clk(CLOCK),
      .rst(RST),
      .ce(CE),
      .restart(rx_restart),
      .src_tick(rx_src),
      .div(div_rx[B_DIV_HI:B_DIV_LO]),
      .half_tick(rx_half_tick)
   );

   suc_baud u_tx_baud (
      .clk(CLOCK),
      .rst(RST),
      .ce(CE),
      .restart(tx_restart),
      .src_tick(opclk_tick),
      .div(div_tx[B_DIV_HI:B_DIV_LO]),
      .half_tick(tx_half_tick)
   );

   // -----------------------------------------------------------------
   // receive channel
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         rx_run <= 1'b0;
      end else if (CE) begin
         if (sw_stop || !rx_ok) begin
            rx_run <= 1'b0;
         end else if (sw_start && mode_rx[B_STS]) begin
            rx_run <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         rx_state <= ST_IDLE;
         rx_half <= 1'b0;
         rx_cnt <= '0;
         rx_shift <= '0;
         rx_data <= '0;
         rx_full <= 1'b0;
         perr <= 1'b0;
         RX_ERROR_IRQ <= 1'b0;
         CHANNEL_IRQ <= 1'b0;
      end else if (CE) begin
         RX_ERROR_IRQ <= 1'b0;
         CHANNEL_IRQ <= 1'b0;
         if (rx_read) begin
            rx_full <= 1'b0;
            CHANNEL_IRQ <= mode_rx[B_IRQSRC];
         end
         if (perr_clr) begin
            perr <= 1'b0;
         end
         if (rx_half_tick) begin
            rx_half <= ~rx_half;
         end
         if (!rx_ok) begin
            rx_state <= ST_IDLE;
         end else begin
            unique case (rx_state)
               ST_IDLE: begin
                  if ((rx_run && start_edge)
                     || (sw_start && !mode_rx[B_STS])) begin
                     rx_state <= ST_START;
                  end
               end
               ST_START: begin
                  // mid start bit; a glitch on an edge start is dropped
                  if (rx_half_tick) begin
                     rx_half <= 1'b0;
                     rx_cnt <= '0;
                     if (mode_rx[B_STS] && rx_lvl) begin
                        rx_state <= ST_IDLE;
                     end else begin
                        rx_state <= ST_DATA;
                     end
                  end
               end
               ST_DATA: begin
                  if (rx_sample) begin
                     rx_shift[rx_cnt] <= rx_lvl;
                     rx_cnt <= rx_cnt + 1'b1;
                     if (rx_cnt == rx_n - 1'b1) begin
                        if (comm_rx[B_PTC_HI:B_PTC_LO] != PAR_NONE) begin
                           rx_state <= ST_PAR;
                        end else if (comm_rx[B_SLC_HI:B_SLC_LO]
                           != STOP_NONE) begin
                           rx_state <= ST_STOP;
                        end else begin
                           rx_state <= ST_IDLE;
                        end
                     end
                  end
               end
               ST_PAR: begin
                  if (rx_sample) begin
                     if (comm_rx[B_PTC_HI] && (rx_lvl != suc_parity(
                        rx_shift, rx_n, comm_rx[B_PTC_HI:B_PTC_LO]))) begin
                        perr <= 1'b1;
                        RX_ERROR_IRQ <= comm_rx[B_EOC];
                     end
                     if (comm_rx[B_SLC_HI:B_SLC_LO] != STOP_NONE) begin
                        rx_state <= ST_STOP;
                     end else begin
                        rx_state <= ST_IDLE;
                     end
                  end
               end
               ST_STOP: begin
                  // the first stop bit ends the frame so a following
                  // start bit is not missed in two-stop traffic
                  if (rx_sample) begin
                     rx_state <= ST_IDLE;
                  end
               end
               default: rx_state <= ST_IDLE;
            endcase
         end
         // frame end: deliver word in order, its last bit stale when neither parity nor stop; channel irq only if frame end is the cause
         if (rx_ok && rx_state != ST_IDLE && rx_state != ST_START
            && rx_sample && (rx_state == ST_STOP
            || (rx_state == ST_PAR
            && comm_rx[B_SLC_HI:B_SLC_LO] == STOP_NONE)
            || (rx_state == ST_DATA && rx_cnt == rx_n - 1'b1
            && comm_rx[B_PTC_HI:B_PTC_LO] == PAR_NONE
            && comm_rx[B_SLC_HI:B_SLC_LO] == STOP_NONE))) begin
            rx_data <= comm_rx[B_DIR] ? rx_shift
               : suc_reverse(rx_shift, rx_n);
            rx_full <= 1'b1;
            CHANNEL_IRQ <= ~mode_rx[B_IRQSRC];
         end
      end
   end

   // -----------------------------------------------------------------
   // transmit channel
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         tx_state <= ST_IDLE;
         tx_half <= 1'b0;
         tx_cnt <= '0;
         tx_word <= '0;
         tx_stops <= '0;
         TXD <= 1'b1;
         TX_END_IRQ <= 1'b0;
      end else if (CE) begin
         TX_END_IRQ <= 1'b0;
         if (tx_half_tick) begin
            tx_half <= ~tx_half;
         end
         unique case (tx_state)
            ST_IDLE: begin
               // a write while busy is dropped; status shows busy
               if (tx_load && comm_tx[B_TXE]) begin
                  tx_word <= comm_tx[B_DIR] ? PWDATA[WORD_W-1:0]
                     : suc_reverse(PWDATA[WORD_W-1:0], tx_n);
                  tx_half <= 1'b0;
                  TXD <= 1'b0;
                  tx_state <= ST_START;
               end
            end
            ST_START: begin
               if (tx_adv) begin
                  TXD <= tx_word[0];
                  tx_cnt <= CNT_W'(1'b1);
                  tx_state <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (tx_adv) begin
                  if (tx_cnt == tx_n) begin
                     if (comm_tx[B_PTC_HI:B_PTC_LO] != PAR_NONE) begin
                        TXD <= suc_parity(tx_word, tx_n,
                           comm_tx[B_PTC_HI:B_PTC_LO]);
                        tx_state <= ST_PAR;
                     end else begin
                        TXD <= 1'b1;
                        tx_stops <= (comm_tx[B_SLC_HI:B_SLC_LO] == STOP_TWO)
                           ? STOPS_TWO : STOPS_ONE;
                        tx_state <= (comm_tx[B_SLC_HI:B_SLC_LO] == STOP_NONE)
                           ? ST_IDLE : ST_STOP;
                        TX_END_IRQ <= comm_tx[B_SLC_HI:B_SLC_LO] == STOP_NONE;
                     end
                  end else begin
                     TXD <= tx_word[tx_cnt];
                     tx_cnt <= tx_cnt + 1'b1;
                  end
               end
            end
            ST_PAR: begin
               if (tx_adv) begin
                  TXD <= 1'b1;
                  tx_stops <= (comm_tx[B_SLC_HI:B_SLC_LO] == STOP_TWO)
                     ? STOPS_TWO : STOPS_ONE;
                  tx_state <= (comm_tx[B_SLC_HI:B_SLC_LO] == STOP_NONE)
                     ? ST_IDLE : ST_STOP;
                  TX_END_IRQ <= comm_tx[B_SLC_HI:B_SLC_LO] == STOP_NONE;
               end
            end
            ST_STOP: begin
               if (tx_adv) begin
                  if (tx_stops == STOPS_ONE) begin
                     tx_state <= ST_IDLE;
                     TX_END_IRQ <= 1'b1;
                  end else begin
                     tx_stops <= tx_stops - 1'b1;
                  end
               end
            end
            default: tx_state <= ST_IDLE;
         endcase
      end
   end
endmodule

// *** verification/suc_uart_setup_properties.sv ***
// port assertions for the serial channel pair
// assumes CE is held high by the bench
`timescale 1ns/1ps
module suc_uart_setup_properties (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic TXD,
   input wire logic RX_ERROR_IRQ,
   input wire logic CHANNEL_IRQ,
   input wire logic TX_END_IRQ
);
   // ----------------------------------------------------------
   // properties
   // ----------------------------------------------------------
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   a_ready_wait: assert property (PSEL && PENABLE && CE && !PREADY |=> PREADY)
      else $error("ready not after one wait state");
   a_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("slave error without ready");
   a_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0)
      else $error("upper read bits set");
   a_stop_high: assert property (TX_END_IRQ |-> TXD)
      else $error("frame end without stop level");
   a_start_len: assert property ($fell(TXD) |=> !TXD)
      else $error("start bit too short");
   a_err_pulse: assert property (RX_ERROR_IRQ |=> !RX_ERROR_IRQ)
      else $error("error irq not a pulse");
   a_chan_pulse: assert property (CHANNEL_IRQ |=> !CHANNEL_IRQ)
      else $error("channel irq not a pulse");
   c_tx_end: cover property (TX_END_IRQ);
   c_rx_err: cover property (RX_ERROR_IRQ);
   c_unmapped: cover property (PREADY && PSLVERR);
endmodule
bind suc_uart_setup suc_uart_setup_properties suc_uart_setup_properties_i (
   .CLOCK, .RST, .CE, .PSEL, .PENABLE, .PWRITE, .PRDATA, .PREADY,
   .PSLVERR, .TXD, .RX_ERROR_IRQ, .CHANNEL_IRQ, .TX_END_IRQ);

// *** verification/suc_remote.sv ***
// remote serial device on the transmit and receive lines
// assumes a bit time of BIT_CYC system clocks
`timescale 1ns/1ps
module suc_remote #(parameter int BIT_CYC = 8) (
   input wire logic clk,
   input wire logic txd,
   output logic rxd
);
   // ----------------------------------------------------------
   // line tasks
   // ----------------------------------------------------------
   initial rxd = 1'b1;
   // start bit, then ten frame bits, first bit in f[0]; idle is high
   task automatic send(input logic [9:0] f);
      rxd <= 1'b0;
      repeat (BIT_CYC) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BIT_CYC) @(posedge clk);
      end
      rxd <= 1'b1;
   endtask
   // samples mid-bit; the tenth sample may fall on idle line
   task automatic recv(output logic [9:0] f);
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         repeat (BIT_CYC) @(posedge clk);
         f[i] = txd;
      end
   endtask
endmodule

// *** verification/suc_uart_setup_bench.sv ***
// self-checking bench for the serial channel pair
// assumes one operation clock tick per cycle and dividers of 3
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
$display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module suc_uart_setup_bench;
   import suc_pkg::*;
   logic CLOCK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic PRESC1_TICK = 0, PREADY, PSLVERR, RXD, TXD, e;
   logic RX_ERROR_IRQ, CHANNEL_IRQ, TX_END_IRQ;
   logic [7:0] PADDR = 0, seed = 8'h2D;
   logic [31:0] PWDATA = 0, PRDATA, q;
   logic [9:0] got;
   int fails = 0, n_checks = 0, cyc = 0, n_err = 0, n_ch = 0, n_end = 0;
   byte unsigned exp_q[$];
   // ----------------------------------------------------------
   // clock, monitors, instances
   // ----------------------------------------------------------
   always #5 CLOCK = ~CLOCK;
   always @(posedge CLOCK) begin
      cyc++;
      PRESC1_TICK <= seed[0];
      n_err += RX_ERROR_IRQ;
      n_ch += CHANNEL_IRQ;
      n_end += TX_END_IRQ;
      if (cyc == 5000) begin
         fails++;
         print_verdict();
      end
   end
   suc_uart_setup suc_uart_setup_i (.CLOCK, .RST, .CE(1'b1), .PSEL,
      .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
      .PRESC0_TICK(1'b1), .PRESC1_TICK, .SCK_IN(1'b0), .RXD, .TXD,
      .RX_ERROR_IRQ, .CHANNEL_IRQ, .TX_END_IRQ);
   suc_remote suc_remote_i (.clk(CLOCK), .txd(TXD), .rxd(RXD));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // expected line bits after the start bit
   function automatic logic [9:0] txf(logic [7:0] d, int p, bit lsb);
      logic [7:0] o;
      for (int i = 0; i < 8; i++) o[i] = lsb ? d[i] : d[7 - i];
      if (p == 0) return {2'b11, o};
      if (p == 1) return {2'b10, o};
      return {1'b1, (^d) ^ (p == 3), o};
   endfunction
   task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do @(posedge CLOCK); while (PREADY !== 1'b1);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK(q, x)
   endtask
   task automatic print_verdict();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      repeat (12) @(posedge CLOCK);
      RST <= 1'b0;
      rd(OFF_MODE_RX, {16'h0, MODE_RX_FIXED});
      rd(OFF_COMM_TX, {16'h0, COMM_FIXED});
      apb(1'b1, OFF_COMM_RX, 32'hFFFFFFFF);
      rd(OFF_COMM_RX, {16'h0, COMM_WMASK | COMM_FIXED});
      rd(8'h40, 32'h0);
      `CHK(e, 1'b1)
      apb(1'b1, OFF_MODE_RX, 32'h0102);
      apb(1'b1, OFF_DIV_TX, 32'h0600);
      apb(1'b1, OFF_DIV_RX, 32'h0600);
      // every parity code; lsb first for codes 1 and 2, msb first for 0 and 3
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, OFF_COMM_TX,
            {17'h1, 5'h0, 2'(k), k[1] ^ k[0], 7'h13});
         seed = lfsr(seed);
         fork
            suc_remote_i.recv(got);
            apb(1'b1, OFF_TXDATA, {24'h0, seed});
         join
         `CHK(got, txf(seed, k, k[1] ^ k[0]))
         while (n_end <= k) @(posedge CLOCK);
      end
      apb(1'b1, OFF_COMM_RX, 32'h4693);
      repeat (4) @(posedge CLOCK);
      apb(1'b1, OFF_CTRL, 32'h1);
      // frame 1 has bad even parity; frame 2 odd check, error masked,
      // channel irq moved to the data read
      for (int j = 0; j < 3; j++) begin
         if (j == 2) begin
            apb(1'b1, OFF_STATUS, 32'h8);
            rd(OFF_STATUS, 32'h4);
            apb(1'b1, OFF_MODE_RX, 32'h0103);
            apb(1'b1, OFF_COMM_RX, 32'h4393);
         end
         seed = lfsr(seed);
         exp_q.push_back(seed);
         @(posedge CLOCK);
         suc_remote_i.send({1'b1, (^seed) ^ j[0], seed});
         rd(OFF_RXDATA, {24'h0, exp_q.pop_front()});
         rd(OFF_STATUS, {28'h0, j != 0, 3'h4});
      end
      // serial clock pin held still: a started frame must stall
      apb(1'b1, OFF_MODE_RX, 32'h4102);
      @(posedge CLOCK);
      suc_remote_i.send(10'h3FF);
      rd(OFF_STATUS, 32'hD);
      `CHK(n_ch, 3)
      `CHK(n_err, 1)
      print_verdict();
   end
endmodule
